//--- rp_pkg.sv
/*
  Shared constants, field layouts and carrier types for the graphics
  root port. Assumes a 64-bit address space and a 28-bit flat
  configuration window on the host side.
*/
package rp_pkg;
  // Address limit: bits at and above this position must stay zero.
  localparam int LIMIT_LSB = 36;
  // Flat configuration window layout (byte address).
  localparam int ECAM_AW = 28;
  localparam int ECAM_BUS_LSB = 20;
  localparam int ECAM_DEV_LSB = 15;
  localparam int ECAM_FN_LSB = 12;
  localparam int ECAM_DW_LSB = 2;
  localparam logic [11:0] CFG_EXT_BASE = 12'h100;
  // Interrupt message window, compared with address bits 31:20.
  localparam int MSI_LSB = 20;
  localparam logic [11:0] MSI_WIN = 12'hfee;
  // Completion status codes.
  localparam logic [2:0] CPL_SC = 3'h0;
  localparam logic [2:0] CPL_UR = 3'h1;
  localparam logic [2:0] CPL_CRS = 3'h2;
  localparam logic [31:0] UR_DATA = 32'hffffffff;
  localparam logic [2:0] VC_ZERO = 3'h0;
  localparam logic [4:0] MAX_LANES = 5'h10;

  typedef enum logic [1:0] {
    RATE_2G5 = 2'h0,
    RATE_5G0 = 2'h1,
    RATE_8G0 = 2'h2
  } rate_e;

  typedef enum logic [1:0] {
    K_MRD = 2'h0,
    K_MWR = 2'h1,
    K_PME = 2'h2
  } kind_e;

  typedef struct packed {
    logic [7:0] bus;
    logic [4:0] dev;
    logic [2:0] fn;
    logic [9:0] dw;
    logic ext;
    logic type1;
    logic we;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_s;

  typedef struct packed {
    logic [2:0] status;
    logic [31:0] data;
  } cfg_cpl_s;

  typedef struct packed {
    kind_e kind;
    logic [63:0] addr;
    logic no_snoop;
    logic relaxed;
    logic [7:0] tag;
    logic [31:0] data;
  } mem_req_s;

  typedef struct packed {
    logic [7:0] tag;
    logic [2:0] status;
  } up_cpl_s;
endpackage

//--- graphics_root_port.sv
/*
  Transaction logic of the graphics root port: link training, config
  request translation and retry, address limit checks, peer filtering
  and interrupt message routing. Assumes the link clock runs freely
  from the shared reference and that the PHY sits on the link side.
*/
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Word crossing by toggle handshake
// ----------------------------------------------------------------
module word_handshake #(
  parameter int W = 8
) (
  // Source side
  input logic s_clk,
  input logic s_rst_b,
  input logic s_valid,
  output logic s_ready,
  input logic [W-1:0] s_data,
  // Destination side
  input logic d_clk,
  input logic d_rst_b,
  output logic d_valid,
  input logic d_ready,
  output logic [W-1:0] d_data
);
  logic req_r, req_nxt, busy_r, busy_nxt, ack_m_r, ack_s_r;
  logic [W-1:0] hold_r, hold_nxt;
  logic req_m_r, req_s_r, seen_r, seen_nxt, ack_r, ack_nxt;
  logic dv_r, dv_nxt;
  logic [W-1:0] dd_r, dd_nxt;

  // The held word stays still while busy, so the far side may take it.
  assign s_ready = !busy_r;
  always_comb begin
    req_nxt = req_r;
    busy_nxt = busy_r;
    hold_nxt = hold_r;
    if (busy_r && ack_s_r == req_r) begin
      busy_nxt = 1'b0;
    end
    if (!busy_r && s_valid) begin
      hold_nxt = s_data;
      req_nxt = !req_r;
      busy_nxt = 1'b1;
    end
  end
  always_ff @(posedge s_clk) begin
    if (!s_rst_b) begin
      req_r <= 1'b0;
      busy_r <= 1'b0;
      hold_r <= '0;
      ack_m_r <= 1'b0;
      ack_s_r <= 1'b0;
    end else begin
      req_r <= req_nxt;
      busy_r <= busy_nxt;
      hold_r <= hold_nxt;
      ack_m_r <= ack_r;
      ack_s_r <= ack_m_r;
    end
  end

  assign d_valid = dv_r;
  assign d_data = dd_r;
  always_comb begin
    seen_nxt = seen_r;
    ack_nxt = ack_r;
    dv_nxt = dv_r;
    dd_nxt = dd_r;
    if (dv_r && d_ready) begin
      dv_nxt = 1'b0;
      ack_nxt = !ack_r;
    end
    if (!dv_r && req_s_r != seen_r) begin
      dv_nxt = 1'b1;
      dd_nxt = hold_r;
      seen_nxt = req_s_r;
    end
  end
  always_ff @(posedge d_clk) begin
    if (!d_rst_b) begin
      req_m_r <= 1'b0;
      req_s_r <= 1'b0;
      seen_r <= 1'b0;
      ack_r <= 1'b0;
      dv_r <= 1'b0;
      dd_r <= '0;
    end else begin
      req_m_r <= req_r;
      req_s_r <= req_m_r;
      seen_r <= seen_nxt;
      ack_r <= ack_nxt;
      dv_r <= dv_nxt;
      dd_r <= dd_nxt;
    end
  end
endmodule

// What this block does
// RULE1 - Train sixteen lanes, settle on x16, x8, x4, x2 or x1.
// RULE2 - Run at 2.5, 5.0 or 8 GT/s.
// RULE3 - 8b/10b coding at the two lower rates, 128b/130b at 8 GT/s.
// RULE4 - Config space is 4 KB; extended region starts at 100h.
// RULE5 - Downstream addresses keep bits 63:36 at zero.
// RULE6 - Upstream reads above 64 GB get an Unsupported Request.
// RULE7 - Upstream writes above 64 GB are silently discarded.
// RULE8 - A config request answered with retry status is sent again.
// RULE9 - Peer traffic passes only as posted writes on channel 0.
// RULE10 - Link trains by itself after reset release.
// RULE11 - Flat config accesses become config requests on the link.
// RULE12 - Software should use aligned 32-bit config accesses.
// RULE13 - No hot-plug detection or signalling.
// RULE14 - Snooped and non-snooped traffic both pass with attributes.
// RULE15 - Both ends time lanes from the shared 100 MHz reference.
// RULE16 - Accept MSI, MSI-X and power-management event messages.
// RULE17 - Link appears as a bridge; bus numbers pick config type.
// RULE18 - Check bits 63:36, then read or write, before routing.
module graphics_root_port #(
  parameter logic [4:0] MAX_WIDTH = 5'h10,
  parameter logic [1:0] MAX_RATE = 2'h2
) (
  // Clocks and reset
  input logic SYS_CLK,
  input logic RST_B,
  input logic LINK_CLK,
  // Training, link clock
  input logic PARTNER_DETECT,
  input logic PARTNER_TRAINED,
  input logic [4:0] PARTNER_WIDTH,
  input rp_pkg::rate_e PARTNER_RATE,
  output logic LINK_UP,
  output logic [4:0] LINK_WIDTH,
  output rp_pkg::rate_e LINK_RATE,
  output logic LINK_ENC_128B,
  // Host configuration access, system clock
  input logic [7:0] SEC_BUS,
  input logic [7:0] SUB_BUS,
  input logic HCFG_VALID,
  output logic HCFG_READY,
  input logic [rp_pkg::ECAM_AW-1:0] HCFG_ADDR,
  input logic HCFG_WE,
  input logic [3:0] HCFG_BE,
  input logic [31:0] HCFG_WDATA,
  output logic HCFG_DONE,
  output rp_pkg::cfg_cpl_s HCFG_CPL,
  output logic LINK_UP_HOST,
  // Downstream memory and peer, system clock
  input logic HMEM_VALID,
  output logic HMEM_READY,
  input rp_pkg::mem_req_s HMEM_REQ,
  input logic PEER_VALID,
  output logic PEER_READY,
  input rp_pkg::mem_req_s PEER_REQ,
  input logic [2:0] PEER_VC,
  output logic PEER_DROP,
  // Upstream toward memory, system clock
  output logic MEM_VALID,
  input logic MEM_READY,
  output rp_pkg::mem_req_s MEM_REQ,
  output logic MSI_EVENT,
  output logic [31:0] MSI_DATA,
  output logic PME_EVENT,
  // Link transaction side, link clock
  output logic DCFG_VALID,
  input logic DCFG_READY,
  output rp_pkg::cfg_req_s DCFG_REQ,
  input logic DCPL_VALID,
  output logic DCPL_READY,
  input rp_pkg::cfg_cpl_s DCPL,
  output logic DMEM_VALID,
  input logic DMEM_READY,
  output rp_pkg::mem_req_s DMEM_REQ,
  input logic UREQ_VALID,
  output logic UREQ_READY,
  input rp_pkg::mem_req_s UREQ,
  output logic UCPL_VALID,
  input logic UCPL_READY,
  output rp_pkg::up_cpl_s UCPL,
  output logic UDROP
);
  import rp_pkg::*;

  typedef enum logic [2:0] {
    T_RESET = 3'b000,
    T_DETECT = 3'b001,
    T_POLL = 3'b011,
    T_CFG = 3'b010,
    T_L0 = 3'b110
  } train_e;

  typedef enum logic [1:0] {
    C_IDLE = 2'b00,
    C_SEND = 2'b01,
    C_WAIT = 2'b11,
    C_DONE = 2'b10
  } cfg_e;

  // ----------------------------------------------------------------
  // Reset into the link domain
  // ----------------------------------------------------------------
  logic lrst_m_r, lrst_b_r, up_m_r, up_s_r;
  always_ff @(posedge LINK_CLK) begin // RULE15
    lrst_m_r <= RST_B;
    lrst_b_r <= lrst_m_r;
  end

  // ----------------------------------------------------------------
  // Link training
  // ----------------------------------------------------------------
  train_e tst_r, tst_nxt;
  logic [4:0] width_r, width_nxt, cap;
  rate_e rate_r, rate_nxt;

  // Widest legal lane count not above both limits.
  function automatic logic [4:0] pick_width(input logic [4:0] lim);
    logic [4:0] w;
    w = 5'h01;
    for (int i = 1; i < 5; i++) begin
      if (lim >= (5'h01 << i)) begin
        w = 5'h01 << i;
      end
    end
    return w;
  endfunction

  assign cap = (PARTNER_WIDTH < MAX_WIDTH) ? PARTNER_WIDTH : MAX_WIDTH;
  always_comb begin
    tst_nxt = tst_r;
    width_nxt = width_r;
    rate_nxt = rate_r;
    case (tst_r)
      T_RESET: tst_nxt = T_DETECT; // RULE10
      T_DETECT: begin
        if (PARTNER_DETECT) begin
          tst_nxt = T_POLL;
        end
      end
      T_POLL: begin
        if (!PARTNER_DETECT) begin
          tst_nxt = T_DETECT;
        end else if (PARTNER_TRAINED) begin
          tst_nxt = T_CFG;
        end
      end
      T_CFG: begin
        width_nxt = pick_width(cap); // RULE1
        rate_nxt = (PARTNER_RATE > MAX_RATE) ? rate_e'(MAX_RATE)
                                             : PARTNER_RATE; // RULE2
        tst_nxt = T_L0;
      end
      // Losing the partner only retrains; there is no removal report.
      T_L0: begin
        if (!PARTNER_DETECT || !PARTNER_TRAINED) begin
          tst_nxt = T_DETECT; // RULE13
        end
      end
      default: tst_nxt = T_RESET;
    endcase
  end
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_b_r) begin
      tst_r <= T_RESET;
      width_r <= 5'h01;
      rate_r <= RATE_2G5;
    end else begin
      tst_r <= tst_nxt;
      width_r <= width_nxt;
      rate_r <= rate_nxt;
    end
  end
  assign LINK_UP = (tst_r == T_L0);
  assign LINK_WIDTH = width_r;
  assign LINK_RATE = rate_r;
  assign LINK_ENC_128B = (rate_r == RATE_8G0); // RULE3

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      up_m_r <= 1'b0;
      up_s_r <= 1'b0;
    end else begin
      up_m_r <= LINK_UP;
      up_s_r <= up_m_r;
    end
  end
  assign LINK_UP_HOST = up_s_r;

  // ----------------------------------------------------------------
  // Configuration translation and retry
  // ----------------------------------------------------------------
  cfg_e cst_r, cst_nxt;
  cfg_req_s creq_r, creq_nxt, hreq;
  cfg_cpl_s ccpl_r, ccpl_nxt, cpl_d;
  logic cfg_s_ready, cpl_d_valid, in_range;

  always_comb begin
    hreq.bus = HCFG_ADDR[ECAM_BUS_LSB +: 8];
    hreq.dev = HCFG_ADDR[ECAM_DEV_LSB +: 5];
    hreq.fn = HCFG_ADDR[ECAM_FN_LSB +: 3];
    hreq.dw = HCFG_ADDR[ECAM_DW_LSB +: 10];
    hreq.ext = (HCFG_ADDR[11:0] >= CFG_EXT_BASE); // RULE4
    hreq.type1 = (hreq.bus != SEC_BUS); // RULE17
    hreq.we = HCFG_WE;
    hreq.be = HCFG_BE;
    hreq.wdata = HCFG_WDATA;
  end
  assign in_range = (hreq.bus >= SEC_BUS) && (hreq.bus <= SUB_BUS);
  assign HCFG_READY = (cst_r == C_IDLE);
  assign HCFG_DONE = (cst_r == C_DONE);
  assign HCFG_CPL = ccpl_r;

  // A target that keeps answering retry stalls the host indefinitely.
  always_comb begin
    cst_nxt = cst_r;
    creq_nxt = creq_r;
    ccpl_nxt = ccpl_r;
    case (cst_r)
      C_IDLE: begin
        if (HCFG_VALID) begin
          creq_nxt = hreq; // RULE11
          if (!up_s_r || !in_range) begin
            ccpl_nxt = '{status: CPL_UR, data: UR_DATA};
            cst_nxt = C_DONE;
          end else begin
            cst_nxt = C_SEND;
          end
        end
      end
      C_SEND: begin
        if (cfg_s_ready) begin
          cst_nxt = C_WAIT;
        end
      end
      C_WAIT: begin
        if (cpl_d_valid) begin
          if (cpl_d.status == CPL_CRS) begin
            cst_nxt = C_SEND; // RULE8
          end else begin
            ccpl_nxt = cpl_d;
            cst_nxt = C_DONE;
          end
        end
      end
      C_DONE: cst_nxt = C_IDLE;
      default: cst_nxt = C_IDLE;
    endcase
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      cst_r <= C_IDLE;
      creq_r <= '0;
      ccpl_r <= '0;
    end else begin
      cst_r <= cst_nxt;
      creq_r <= creq_nxt;
      ccpl_r <= ccpl_nxt;
    end
  end

  word_handshake #(.W($bits(cfg_req_s))) u_cfg (
    .s_clk(SYS_CLK), .s_rst_b(RST_B),
    .s_valid(cst_r == C_SEND), .s_ready(cfg_s_ready), .s_data(creq_r),
    .d_clk(LINK_CLK), .d_rst_b(lrst_b_r),
    .d_valid(DCFG_VALID), .d_ready(DCFG_READY), .d_data(DCFG_REQ)
  );
  word_handshake #(.W($bits(cfg_cpl_s))) u_cpl (
    .s_clk(LINK_CLK), .s_rst_b(lrst_b_r),
    .s_valid(DCPL_VALID), .s_ready(DCPL_READY), .s_data(DCPL),
    .d_clk(SYS_CLK), .d_rst_b(RST_B),
    .d_valid(cpl_d_valid), .d_ready(cst_r == C_WAIT), .d_data(cpl_d)
  );

  // ----------------------------------------------------------------
  // Downstream memory and peer writes
  // ----------------------------------------------------------------
  logic peer_bad, dn_s_valid, dn_s_ready, drop_r;
  mem_req_s dn_s_data;

  assign peer_bad = (PEER_REQ.kind != K_MWR) || (PEER_VC != VC_ZERO);
  assign dn_s_valid = HMEM_VALID || (PEER_VALID && !peer_bad); // RULE9
  always_comb begin
    dn_s_data = HMEM_VALID ? HMEM_REQ : PEER_REQ; // RULE14
    dn_s_data.addr[63:LIMIT_LSB] = '0; // RULE5
  end
  assign HMEM_READY = dn_s_ready;
  assign PEER_READY = peer_bad || (!HMEM_VALID && dn_s_ready);
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      drop_r <= 1'b0;
    end else begin
      drop_r <= PEER_VALID && peer_bad;
    end
  end
  assign PEER_DROP = drop_r;

  word_handshake #(.W($bits(mem_req_s))) u_dn (
    .s_clk(SYS_CLK), .s_rst_b(RST_B),
    .s_valid(dn_s_valid), .s_ready(dn_s_ready), .s_data(dn_s_data),
    .d_clk(LINK_CLK), .d_rst_b(lrst_b_r),
    .d_valid(DMEM_VALID), .d_ready(DMEM_READY), .d_data(DMEM_REQ)
  );

  // ----------------------------------------------------------------
  // Upstream address check
  // ----------------------------------------------------------------
  logic over, rd, up_s_ready, ucv_r, ucv_nxt, udrop_r;
  up_cpl_s uc_r, uc_nxt;

  // Messages carry no address and bypass the limit check.
  assign over = (UREQ.kind != K_PME) && (|UREQ.addr[63:LIMIT_LSB]);
  assign rd = (UREQ.kind == K_MRD); // RULE18
  assign UREQ_READY = over ? (rd ? !ucv_r : 1'b1) : up_s_ready; // RULE7
  always_comb begin
    ucv_nxt = ucv_r;
    uc_nxt = uc_r;
    if (ucv_r && UCPL_READY) begin
      ucv_nxt = 1'b0;
    end
    if (UREQ_VALID && over && rd && !ucv_r) begin
      ucv_nxt = 1'b1; // RULE6
      uc_nxt = '{tag: UREQ.tag, status: CPL_UR};
    end
  end
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_b_r) begin
      ucv_r <= 1'b0;
      uc_r <= '0;
      udrop_r <= 1'b0;
    end else begin
      ucv_r <= ucv_nxt;
      uc_r <= uc_nxt;
      udrop_r <= UREQ_VALID && over && !rd;
    end
  end
  assign UCPL_VALID = ucv_r;
  assign UCPL = uc_r;
  assign UDROP = udrop_r;

  // ----------------------------------------------------------------
  // Upstream routing to memory and interrupt events
  // ----------------------------------------------------------------
  logic up_d_valid, is_msi, is_pme, msi_r, pme_r;
  logic [31:0] msid_r;
  mem_req_s up_d;

  word_handshake #(.W($bits(mem_req_s))) u_up (
    .s_clk(LINK_CLK), .s_rst_b(lrst_b_r),
    .s_valid(UREQ_VALID && !over), .s_ready(up_s_ready), .s_data(UREQ),
    .d_clk(SYS_CLK), .d_rst_b(RST_B),
    .d_valid(up_d_valid), .d_ready(is_msi || is_pme || MEM_READY),
    .d_data(up_d)
  );
  // MSI and MSI-X look alike on the wire: a write into the window.
  assign is_pme = (up_d.kind == K_PME);
  assign is_msi = (up_d.kind == K_MWR) &&
                  (up_d.addr[MSI_LSB +: 12] == MSI_WIN);
  assign MEM_VALID = up_d_valid && !is_msi && !is_pme;
  assign MEM_REQ = up_d;
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      msi_r <= 1'b0;
      pme_r <= 1'b0;
      msid_r <= '0;
    end else begin
      msi_r <= up_d_valid && is_msi; // RULE16
      pme_r <= up_d_valid && is_pme; // RULE16
      msid_r <= (up_d_valid && is_msi) ? up_d.data : msid_r;
    end
  end
  assign MSI_EVENT = msi_r;
  assign MSI_DATA = msid_r;
  assign PME_EVENT = pme_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  over_read_ur_a: assert property ( // RULE6
    @(posedge LINK_CLK) disable iff (!lrst_b_r)
    UREQ_VALID && UREQ_READY && over && rd |=>
      UCPL_VALID && UCPL.status == CPL_UR && UCPL.tag == $past(UREQ.tag))
    else $error("over-limit read not answered with UR");
  over_write_drop_a: assert property ( // RULE7
    @(posedge LINK_CLK) disable iff (!lrst_b_r)
    UREQ_VALID && over && !rd |-> UREQ_READY ##1 UDROP && !UCPL_VALID)
    else $error("over-limit write not dropped");
  dn_addr_zero_a: assert property ( // RULE5
    @(posedge LINK_CLK) disable iff (!lrst_b_r)
    DMEM_VALID |-> DMEM_REQ.addr[63:LIMIT_LSB] == '0)
    else $error("downstream address above limit");
  crs_retry_a: assert property ( // RULE8
    @(posedge SYS_CLK) disable iff (!RST_B)
    cst_r == C_WAIT && cpl_d_valid && cpl_d.status == CPL_CRS |=>
      cst_r == C_SEND && !HCFG_DONE)
    else $error("retry completion not reissued");
  peer_read_a: assert property ( // RULE9
    @(posedge SYS_CLK) disable iff (!RST_B)
    PEER_VALID && peer_bad && !HMEM_VALID |-> PEER_READY && !dn_s_valid
      ##1 PEER_DROP)
    else $error("bad peer request forwarded");
  train_auto_a: assert property ( // RULE10
    @(posedge LINK_CLK) disable iff (!lrst_b_r)
    tst_r == T_POLL && PARTNER_DETECT && PARTNER_TRAINED |=>
      !LINK_UP ##1 LINK_UP)
    else $error("link did not train");
  width_rate_a: assert property ( // RULE1
    @(posedge LINK_CLK) disable iff (!lrst_b_r)
    LINK_UP |-> $onehot(LINK_WIDTH) && LINK_WIDTH <= MAX_LANES &&
      LINK_ENC_128B == (LINK_RATE == RATE_8G0))
    else $error("illegal width or encoding");
  cfg_ur_a: assert property ( // RULE11
    @(posedge SYS_CLK) disable iff (!RST_B)
    HCFG_VALID && HCFG_READY && !up_s_r |=>
      HCFG_DONE && HCFG_CPL.status == CPL_UR)
    else $error("config with link down not refused");
endmodule

//--- ep_model.sv
/*
  Behavioural endpoint on the link side of the graphics root port.
  Assumes the bench toggles LINK_CLK and steers the model's knobs.
*/
`timescale 1ns/1ps

// ------------------------------------------------------------
// Endpoint model
// ------------------------------------------------------------
module ep_model
  import rp_pkg::*;
(
  // Link clock and training
  input logic LINK_CLK,
  output logic PARTNER_DETECT,
  output logic PARTNER_TRAINED,
  output logic [4:0] PARTNER_WIDTH,
  output rp_pkg::rate_e PARTNER_RATE,
  // Config requests and completions
  input logic DCFG_VALID,
  output logic DCFG_READY,
  input rp_pkg::cfg_req_s DCFG_REQ,
  output logic DCPL_VALID,
  input logic DCPL_READY,
  output rp_pkg::cfg_cpl_s DCPL,
  // Memory traffic
  input logic DMEM_VALID,
  output logic DMEM_READY,
  input rp_pkg::mem_req_s DMEM_REQ,
  output logic UREQ_VALID,
  input logic UREQ_READY,
  output rp_pkg::mem_req_s UREQ,
  input logic UCPL_VALID,
  output logic UCPL_READY,
  input rp_pkg::up_cpl_s UCPL,
  input logic UDROP
);
  logic present = 1'b0;
  logic slow = 1'b0;
  logic [4:0] pw = 5'h10;
  rate_e pr = RATE_8G0;
  int crs_left = 0;
  int cfg_n = 0;
  int dmem_n = 0;
  int drop_n = 0;
  logic pend = 1'b0;
  cfg_req_s last_cfg;
  mem_req_s last_mem;
  up_cpl_s last_ucpl;

  initial begin
    PARTNER_DETECT = 1'b0;
    PARTNER_TRAINED = 1'b0;
    PARTNER_WIDTH = 5'h01;
    PARTNER_RATE = RATE_2G5;
    DCFG_READY = 1'b0;
    DCPL_VALID = 1'b0;
    DCPL = '0;
    DMEM_READY = 1'b0;
    UREQ_VALID = 1'b0;
    UREQ = '0;
    UCPL_READY = 1'b1;
  end

  // Both ends share LINK_CLK, standing in for the common reference.
  always @(posedge LINK_CLK) begin
    PARTNER_DETECT <= present;
    PARTNER_TRAINED <= PARTNER_DETECT && present;
    PARTNER_WIDTH <= pw;
    PARTNER_RATE <= pr;
    DCFG_READY <= slow ? ~DCFG_READY : 1'b1;
    DMEM_READY <= slow ? ~DMEM_READY : 1'b1;
    if (DMEM_VALID && DMEM_READY) begin
      last_mem <= DMEM_REQ;
      dmem_n <= dmem_n + 1;
    end
    if (DCFG_VALID && DCFG_READY) begin
      last_cfg <= DCFG_REQ;
      cfg_n <= cfg_n + 1;
      pend <= 1'b1;
    end
    if (UCPL_VALID && UCPL_READY) last_ucpl <= UCPL;
    if (UDROP) drop_n <= drop_n + 1;
    // An idle completion bus keeps changing, so stale data never
    // passes for an answer.
    if (DCPL_VALID && DCPL_READY) begin
      DCPL_VALID <= 1'b0;
      DCPL <= ~DCPL;
    end else if (pend && !DCPL_VALID) begin
      pend <= 1'b0;
      DCPL_VALID <= 1'b1;
      DCPL.status <= crs_left > 0 ? CPL_CRS : CPL_SC;
      DCPL.data <= {last_cfg.bus, 8'h5a, 6'h00, last_cfg.dw};
      crs_left <= crs_left > 0 ? crs_left - 1 : 0;
    end else if (!DCPL_VALID) DCPL <= ~DCPL;
  end

  task automatic up(input mem_req_s r);
    @(posedge LINK_CLK);
    UREQ <= r;
    UREQ_VALID <= 1'b1;
    @(negedge LINK_CLK);
    while (!UREQ_READY) @(negedge LINK_CLK);
    @(posedge LINK_CLK);
    UREQ_VALID <= 1'b0;
    UREQ <= ~r;
  endtask
endmodule

//--- graphics_root_port_test.sv
/*
  Self-checking bench for the graphics root port.
  Assumes the endpoint model stands on the link side.
*/
`timescale 1ns/1ps

// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module graphics_root_port_test;
  import rp_pkg::*;
  logic SYS_CLK = 1'b0;
  logic LINK_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic PARTNER_DETECT, PARTNER_TRAINED, LINK_UP, LINK_ENC_128B;
  logic [4:0] PARTNER_WIDTH, LINK_WIDTH;
  rate_e PARTNER_RATE, LINK_RATE;
  logic [7:0] SEC_BUS = 8'h02;
  logic [7:0] SUB_BUS = 8'h05;
  logic HCFG_VALID = 1'b0;
  logic HCFG_WE = 1'b0;
  logic [27:0] HCFG_ADDR = '0;
  logic [3:0] HCFG_BE = 4'hf;
  logic [31:0] HCFG_WDATA = 32'h1234abcd;
  logic HMEM_VALID = 1'b0;
  logic PEER_VALID = 1'b0;
  logic MEM_READY = 1'b0;
  logic [2:0] PEER_VC = '0;
  mem_req_s HMEM_REQ = '0;
  mem_req_s PEER_REQ = '0;
  mem_req_s MEM_REQ, DMEM_REQ, UREQ, last_up;
  cfg_req_s DCFG_REQ;
  cfg_cpl_s HCFG_CPL, DCPL;
  up_cpl_s UCPL;
  logic [31:0] MSI_DATA;
  logic LINK_UP_HOST, HCFG_READY, HCFG_DONE, HMEM_READY, PEER_READY;
  logic PEER_DROP, MEM_VALID, MSI_EVENT, PME_EVENT, DCFG_VALID;
  logic DCFG_READY, DCPL_VALID, DCPL_READY, DMEM_VALID, DMEM_READY;
  logic UREQ_VALID, UREQ_READY, UCPL_VALID, UCPL_READY, UDROP;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  int msi_n = 0;
  int pme_n = 0;
  int drop_n = 0;
  int mem_n = 0;

  graphics_root_port graphics_root_port_inst (.*);
  ep_model ep_model_inst (.*);

  always #5 SYS_CLK = ~SYS_CLK;
  always #24 LINK_CLK = ~LINK_CLK;

  // Memory side stalls every other cycle to exercise the hold.
  always @(posedge SYS_CLK) begin
    cycles <= cycles + 1;
    MEM_READY <= ~MEM_READY;
    if (MSI_EVENT) msi_n <= msi_n + 1;
    if (PME_EVENT) pme_n <= pme_n + 1;
    if (PEER_DROP) drop_n <= drop_n + 1;
    if (MEM_VALID && MEM_READY) begin
      last_up <= MEM_REQ;
      mem_n <= mem_n + 1;
    end
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic check(input logic [127:0] seen, exp, input string m);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic settle();
    repeat (40) @(negedge SYS_CLK);
  endtask

  task automatic t_train();
    logic [13:0] tbl [4];
    tbl = '{{5'h0c, 2'h1, 5'h08, 2'h1}, {5'h03, 2'h0, 5'h02, 2'h0},
            {5'h01, 2'h2, 5'h01, 2'h2}, {5'h10, 2'h2, 5'h10, 2'h2}};
    foreach (tbl[i]) begin
      ep_model_inst.present = 1'b0;
      repeat (6) @(negedge LINK_CLK);
      check(LINK_UP, 1'b0, "link up");
      host_cfg({8'h03, 5'h00, 3'h0, 10'h000, 2'h0}, 1'b0);
      check(HCFG_CPL, {CPL_UR, UR_DATA}, "link down");
      ep_model_inst.pw = tbl[i][13:9];
      ep_model_inst.pr = rate_e'(tbl[i][8:7]);
      ep_model_inst.present = 1'b1;
      repeat (10) @(negedge LINK_CLK);
      check(LINK_UP, 1'b1, "link up");
      check(LINK_WIDTH, tbl[i][6:2], "width");
      check(LINK_RATE, tbl[i][1:0], "rate");
      check(LINK_ENC_128B, tbl[i][1:0] == 2'h2, "coding");
    end
  endtask

  task automatic host_cfg(input logic [27:0] a, input logic we);
    int i;
    @(posedge SYS_CLK);
    HCFG_ADDR <= a;
    HCFG_WE <= we;
    HCFG_VALID <= 1'b1;
    @(negedge SYS_CLK);
    while (!HCFG_READY) @(negedge SYS_CLK);
    @(posedge SYS_CLK);
    HCFG_VALID <= 1'b0;
    HCFG_ADDR <= ~a;
    for (i = 0; i < 3000 && HCFG_DONE !== 1'b1; i++) @(negedge SYS_CLK);
    check(HCFG_DONE, 1'b1, "cfg done");
  endtask

  // Accesses are whole aligned dwords.
  task automatic t_cfg();
    cfg_req_s q;
    int n;
    settle();
    check(LINK_UP_HOST, 1'b1, "host link");
    ep_model_inst.crs_left = 1;
    n = ep_model_inst.cfg_n;
    host_cfg({8'h03, 5'h04, 3'h1, 10'h041, 2'h0}, 1'b0);
    check(ep_model_inst.cfg_n - n, 2, "retry");
    q = ep_model_inst.last_cfg;
    check({q.bus, q.dev, q.fn, q.dw, q.ext, q.type1, q.we},
          {8'h03, 5'h04, 3'h1, 10'h041, 3'b110}, "cfg req");
    check(HCFG_CPL, {CPL_SC, 8'h03, 8'h5a, 6'h00, 10'h041}, "cpl");
    host_cfg({8'h02, 5'h00, 3'h0, 10'h03f, 2'h0}, 1'b1);
    q = ep_model_inst.last_cfg;
    check({q.ext, q.type1, q.we, q.wdata}, {3'b001, 32'h1234abcd},
          "cfg wr");
    host_cfg({8'h06, 5'h00, 3'h0, 10'h000, 2'h0}, 1'b0);
    check(HCFG_CPL, {CPL_UR, UR_DATA}, "bus range");
  endtask

  task automatic push(input logic peer, input mem_req_s r,
                      input logic [2:0] vc);
    @(posedge SYS_CLK);
    PEER_REQ <= r;
    HMEM_REQ <= r;
    PEER_VC <= vc;
    PEER_VALID <= peer;
    HMEM_VALID <= !peer;
    @(negedge SYS_CLK);
    while (!(peer ? PEER_READY : HMEM_READY)) @(negedge SYS_CLK);
    @(posedge SYS_CLK);
    PEER_VALID <= 1'b0;
    HMEM_VALID <= 1'b0;
    PEER_REQ <= ~r;
    HMEM_REQ <= ~r;
  endtask

  task automatic t_down();
    mem_req_s r;
    int i;
    int d;
    int m;
    r = '{K_MWR, 64'h0000_0150_2345_6780, 1'b1, 1'b1, 8'h11, 32'hcafe0001};
    ep_model_inst.slow = 1'b1;
    push(1'b0, r, 3'h0);
    settle();
    r.addr = 64'h0000_0000_2345_6780;
    check(ep_model_inst.last_mem, r, "down addr");
    for (int k = 0; k < 3; k++) begin
      r.kind = k == 0 ? K_MRD : K_MWR;
      d = drop_n;
      m = ep_model_inst.dmem_n;
      push(1'b1, r, k == 1 ? 3'h1 : 3'h0);
      for (i = 0; i < 12 && ep_model_inst.dmem_n == m; i++)
        @(negedge LINK_CLK);
      check(drop_n - d, k < 2, "peer drop");
      check(ep_model_inst.dmem_n - m, k == 2, "peer pass");
    end
    ep_model_inst.slow = 1'b0;
  endtask

  task automatic t_up();
    mem_req_s r;
    int n;
    int d;
    r = '{K_MRD, 64'h0000_0010_0000_0040, 1'b0, 1'b0, 8'h2c, 32'h0};
    ep_model_inst.up(r);
    settle();
    check(ep_model_inst.last_ucpl, {8'h2c, CPL_UR}, "ur");
    n = mem_n;
    d = ep_model_inst.drop_n;
    r.kind = K_MWR;
    ep_model_inst.up(r);
    settle();
    check(ep_model_inst.drop_n - d, 1, "drop");
    check(mem_n - n, 0, "no write");
    r.addr = 64'h0000_000f_ffff_fff0;
    r.no_snoop = 1'b1;
    ep_model_inst.up(r);
    settle();
    check(last_up, r, "up write");
    n = msi_n;
    r.addr = 64'h0000_0000_fee0_0010;
    r.data = 32'h0000_4455;
    ep_model_inst.up(r);
    settle();
    check(msi_n - n, 1, "msi");
    check(MSI_DATA, 32'h0000_4455, "msi data");
    n = pme_n;
    r.kind = K_PME;
    ep_model_inst.up(r);
    settle();
    check(pme_n - n, 1, "pme");
  endtask

  initial begin
    repeat (16) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    repeat (4) @(posedge LINK_CLK);
    t_train();
    t_cfg();
    t_down();
    t_up();
    wrap_up();
  end
endmodule
